/* design/spmc_pkg.sv */
package spmc_pkg;

	// Register byte addresses on the AHB-Lite slave
	localparam logic [3:0] SPMC_ADDR_CTRL = 4'h0;
	localparam logic [3:0] SPMC_ADDR_STAT = 4'h4;
	localparam logic [3:0] SPMC_ADDR_DATA = 4'h8;

	// Control register fields
	localparam int SPMC_CTRL_IE = 7;
	localparam int SPMC_CTRL_EN = 6;
	localparam int SPMC_CTRL_ORDER = 5;
	localparam int SPMC_CTRL_MASTER = 4;
	localparam int SPMC_CTRL_CLOCK_POLARITY_BIT = 3;
	localparam int SPMC_CTRL_CLOCK_PHASE_BIT = 2;
	localparam int SPMC_CTRL_RATE_HI = 1;
	localparam int SPMC_CTRL_RATE_LO = 0;

	// Status register fields
	localparam int SPMC_STAT_DONE = 7;
	localparam int SPMC_STAT_WRITE_COLLISION_FLAG = 6;
	localparam int SPMC_STAT_X2 = 0;

	// Reset values
	localparam logic [7:0] SPMC_CTRL_RESET = 8'h00;
	localparam logic [7:0] SPMC_STAT_RESET = 8'h00;
	localparam logic [7:0] SPMC_DATA_RESET = 8'h00;

	// Half serial clock periods in hclk cycles, normal speed (divide 4/16/64/128)
	localparam logic [6:0] SPMC_HALF_N0 = 7'h02;
	localparam logic [6:0] SPMC_HALF_N1 = 7'h08;
	localparam logic [6:0] SPMC_HALF_N2 = 7'h20;
	localparam logic [6:0] SPMC_HALF_N3 = 7'h40;
	// Double speed (divide 2/8/32/64)
	localparam logic [6:0] SPMC_HALF_D0 = 7'h01;
	localparam logic [6:0] SPMC_HALF_D1 = 7'h04;
	localparam logic [6:0] SPMC_HALF_D2 = 7'h10;
	localparam logic [6:0] SPMC_HALF_D3 = 7'h20;

	// Sixteen clock edges make one byte
	localparam logic [3:0] SPMC_LAST_EDGE = 4'hf;

	// Master shift engine states
	typedef enum logic [1:0] {
		SPMC_M_IDLE = 2'b00,
		SPMC_M_RUN = 2'b01
	} spmc_mstate_t;

endpackage

/* design/spmc_top.sv */
// The register offsets and the AHB-Lite slave port were left to the implementer.
module spmc_top
	import spmc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic global_irq_en,
	input wire logic irq_ack,
	output logic irq,
	input wire logic ss_is_input,
	input wire logic ss_n_i,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe
);

	// Registers and state
	logic [7:0] ctrl_reg;
	logic done_reg;
	logic write_collision_flag_reg;
	logic x2_reg;
	logic [7:0] rx_buf_reg;
	logic [7:0] tx_reg;
	logic [7:0] rx_reg;
	logic [3:0] edge_cnt_reg;
	logic [6:0] div_reg;
	logic sck_int_reg;
	logic sck_prev_reg;
	spmc_mstate_t mstate_reg;
	logic arm_done_reg;
	logic arm_write_collision_flag_reg;
	logic dph_valid_reg;
	logic dph_write_reg;
	logic [3:0] dph_addr_reg;
	logic [1:0] ss_sync_reg;
	logic [1:0] sck_sync_reg;
	logic [1:0] mosi_sync_reg;
	logic [1:0] miso_sync_reg;

	// Decoded controls
	logic en, is_master, clock_polarity_bit, clock_phase_bit, lsb_first, ss_low, mode_fault;
	logic slave_active, running, busy, ev, lead, sample_edge, setup_edge;
	logic byte_done, in_bit, out_bit, wr_ctrl, wr_stat, wr_data, data_acc, rd_stat;
	logic [6:0] half;
	logic [7:0] wdata;
	logic [7:0] rd_mux;

	assign en = ctrl_reg[SPMC_CTRL_EN];
	assign is_master = ctrl_reg[SPMC_CTRL_MASTER];
	assign clock_polarity_bit = ctrl_reg[SPMC_CTRL_CLOCK_POLARITY_BIT];
	assign clock_phase_bit = ctrl_reg[SPMC_CTRL_CLOCK_PHASE_BIT];
	assign lsb_first = ctrl_reg[SPMC_CTRL_ORDER];
	assign wdata = hwdata[7:0];

	// Pin inputs cross two flops before use; only the second stage is read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ss_sync_reg <= 2'h3;
			sck_sync_reg <= 2'h0;
			mosi_sync_reg <= 2'h0;
			miso_sync_reg <= 2'h0;
		end else if (clk_en) begin
			ss_sync_reg <= {ss_sync_reg[0], ss_n_i};
			sck_sync_reg <= {sck_sync_reg[0], sck_i};
			mosi_sync_reg <= {mosi_sync_reg[0], mosi_i};
			miso_sync_reg <= {miso_sync_reg[0], miso_i};
		end
	end

	assign ss_low = !ss_sync_reg[1];
	// Another master pulled select low while we drive the bus
	assign mode_fault = en && is_master && ss_is_input && ss_low;
	// Slave only listens while selected; select high holds it in reset
	assign slave_active = en && !is_master && ss_low;
	assign running = (mstate_reg == SPMC_M_RUN);
	assign busy = running || (slave_active && (edge_cnt_reg != 4'h0));

	// Divider selection, consulted only by the master clock generator
	always_comb begin
		case ({x2_reg, ctrl_reg[SPMC_CTRL_RATE_HI:SPMC_CTRL_RATE_LO]})
			3'b000: half = SPMC_HALF_N0;
			3'b001: half = SPMC_HALF_N1;
			3'b010: half = SPMC_HALF_N2;
			3'b011: half = SPMC_HALF_N3;
			3'b100: half = SPMC_HALF_D0;
			3'b101: half = SPMC_HALF_D1;
			3'b110: half = SPMC_HALF_D2;
			3'b111: half = SPMC_HALF_D3;
			default: half = SPMC_HALF_N0;
		endcase
	end

	// One serial clock edge event, from our divider or the external pin
	always_comb begin
		if (running) begin
			ev = (div_reg == half - 7'h01);
			lead = (sck_int_reg == clock_polarity_bit);
		end else if (slave_active) begin
			ev = (sck_sync_reg[1] != sck_prev_reg);
			lead = (sck_sync_reg[1] != clock_polarity_bit);
		end else begin
			ev = 1'b0;
			lead = 1'b0;
		end
	end

	// Mode = {polarity, phase}; phase 0 samples on leading edge
	assign sample_edge = ev && (lead ^ clock_phase_bit);
	// Setup on the other edge; first phase-1 leading edge keeps bit one
	assign setup_edge = ev && !(lead ^ clock_phase_bit) && !(clock_phase_bit && edge_cnt_reg == 4'h0);
	assign byte_done = ev && (edge_cnt_reg == SPMC_LAST_EDGE);
	assign in_bit = is_master ? miso_sync_reg[1] : mosi_sync_reg[1];
	assign out_bit = lsb_first ? tx_reg[0] : tx_reg[7];

	// Bus decode: capture the address phase, act in the data phase
	assign wr_ctrl = dph_valid_reg && dph_write_reg && (dph_addr_reg == SPMC_ADDR_CTRL);
	assign wr_stat = dph_valid_reg && dph_write_reg && (dph_addr_reg == SPMC_ADDR_STAT);
	assign wr_data = dph_valid_reg && dph_write_reg && (dph_addr_reg == SPMC_ADDR_DATA);
	assign data_acc = dph_valid_reg && (dph_addr_reg == SPMC_ADDR_DATA);
	assign rd_stat = dph_valid_reg && !dph_write_reg && (dph_addr_reg == SPMC_ADDR_STAT);

	// Address phase latch; zero wait states so hready is always ours
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_valid_reg <= 1'b0;
			dph_write_reg <= 1'b0;
			dph_addr_reg <= 4'h0;
		end else if (clk_en) begin
			dph_valid_reg <= hsel && htrans[1] && hready;
			dph_write_reg <= hwrite;
			dph_addr_reg <= (haddr[31:4] == 28'h0000000) ? haddr[3:0] : 4'hc;
		end
	end

	// Read value picked in the address phase; status bits five to one are zero
	always_comb begin
		case ((haddr[31:4] == 28'h0000000) ? haddr[3:0] : 4'hc)
			SPMC_ADDR_CTRL: rd_mux = ctrl_reg;
			SPMC_ADDR_STAT: rd_mux = {done_reg, write_collision_flag_reg, 5'h00, x2_reg};
			SPMC_ADDR_DATA: rd_mux = rx_buf_reg;
			default: rd_mux = 8'h00;
		endcase
	end

	// Bus answers: read data registered at the end of the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
		end else if (clk_en) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hsel && htrans[1] && hready && !hwrite) begin
				hrdata <= {24'h000000, rd_mux};
			end
		end
	end

	// Control register; a mode fault clears the master bit over a same-cycle software write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= SPMC_CTRL_RESET;
		end else if (clk_en) begin
			if (wr_ctrl) begin
				ctrl_reg <= wdata;
			end
			if (mode_fault) begin
				ctrl_reg[SPMC_CTRL_MASTER] <= 1'b0;
			end
		end
	end

	// Double speed bit is the only writable status bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			x2_reg <= SPMC_STAT_RESET[SPMC_STAT_X2];
		end else if (clk_en && wr_stat) begin
			x2_reg <= wdata[SPMC_STAT_X2];
		end
	end

	// Arming for the read-status-then-access-data clear sequence
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			arm_done_reg <= 1'b0;
			arm_write_collision_flag_reg <= 1'b0;
		end else if (clk_en) begin
			if (rd_stat) begin
				arm_done_reg <= done_reg;
				arm_write_collision_flag_reg <= write_collision_flag_reg;
			end else if (data_acc) begin
				arm_done_reg <= 1'b0;
				arm_write_collision_flag_reg <= 1'b0;
			end
		end
	end

	// Done flag: sets win over every clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_reg <= SPMC_STAT_RESET[SPMC_STAT_DONE];
		end else if (clk_en) begin
			if (byte_done || mode_fault) begin
				done_reg <= 1'b1;
			end else if (irq_ack) begin
				done_reg <= 1'b0;
			end else if (data_acc && (arm_done_reg || arm_write_collision_flag_reg)) begin
				done_reg <= 1'b0;
			end
		end
	end

	// Collision flag: writing data while a byte is on the wire
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			write_collision_flag_reg <= SPMC_STAT_RESET[SPMC_STAT_WRITE_COLLISION_FLAG];
		end else if (clk_en) begin
			if (wr_data && busy) begin
				write_collision_flag_reg <= 1'b1;
			end else if (data_acc && arm_write_collision_flag_reg) begin
				write_collision_flag_reg <= 1'b0;
			end
		end
	end

	// Interrupt request, registered so the output is glitch free
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= ctrl_reg[SPMC_CTRL_IE] && done_reg && global_irq_en;
		end
	end

	// Master sequencer: starts on a data write, stops after 16 edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mstate_reg <= SPMC_M_IDLE;
		end else if (clk_en) begin
			case (mstate_reg)
				SPMC_M_IDLE: begin
					if (wr_data && en && is_master && !mode_fault) begin
						mstate_reg <= SPMC_M_RUN;
					end
				end
				SPMC_M_RUN: begin
					if (mode_fault || !en || !is_master || byte_done) begin
						mstate_reg <= SPMC_M_IDLE;
					end
				end
				default: mstate_reg <= SPMC_M_IDLE;
			endcase
		end
	end

	// Clock divider and internal clock; idle level follows polarity
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_reg <= 7'h00;
			sck_int_reg <= 1'b0;
		end else if (clk_en) begin
			if (!running) begin
				div_reg <= 7'h00;
				sck_int_reg <= clock_polarity_bit;
			end else if (ev) begin
				div_reg <= 7'h00;
				sck_int_reg <= !sck_int_reg;
			end else begin
				div_reg <= div_reg + 7'h01;
			end
		end
	end

	// Edge tracking for the slave edge detector
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_prev_reg <= 1'b0;
		end else if (clk_en) begin
			sck_prev_reg <= slave_active ? sck_sync_reg[1] : clock_polarity_bit;
		end
	end

	// Edge counter; select high wipes a partial slave byte at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_cnt_reg <= 4'h0;
		end else if (clk_en) begin
			if (!running && !slave_active) begin
				edge_cnt_reg <= 4'h0;
			end else if (ev) begin
				edge_cnt_reg <= edge_cnt_reg + 4'h1;
			end
		end
	end

	// Receive shifter takes a bit on each sample edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_reg <= 8'h00;
		end else if (clk_en) begin
			if (!running && !slave_active) begin
				rx_reg <= 8'h00;
			end else if (sample_edge) begin
				rx_reg <= lsb_first ? {in_bit, rx_reg[7:1]} : {rx_reg[6:0], in_bit};
			end
		end
	end

	// Receive buffer: overwritten by each byte, unread data is lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_buf_reg <= SPMC_DATA_RESET;
		end else if (clk_en && byte_done) begin
			if (sample_edge) begin
				rx_buf_reg <= lsb_first ? {in_bit, rx_reg[7:1]} : {rx_reg[6:0], in_bit};
			end else begin
				rx_buf_reg <= rx_reg;
			end
		end
	end

	// Transmit shifter: single buffered, writes while busy are dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_reg <= SPMC_DATA_RESET;
		end else if (clk_en) begin
			if (wr_data && !busy) begin
				tx_reg <= wdata;
			end else if (setup_edge) begin
				tx_reg <= lsb_first ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
			end
		end
	end

	// Pin drivers, one register stage so clock and data move together
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_o <= 1'b0;
			sck_oe <= 1'b0;
			mosi_o <= 1'b0;
			mosi_oe <= 1'b0;
			miso_o <= 1'b0;
			miso_oe <= 1'b0;
		end else if (clk_en) begin
			sck_o <= sck_int_reg;
			sck_oe <= en && is_master && !mode_fault;
			mosi_o <= out_bit;
			mosi_oe <= en && is_master && !mode_fault;
			miso_o <= out_bit;
			miso_oe <= slave_active;
		end
	end

endmodule

/* dv/spmc_assertions.sv */
module spmc_checker
	import spmc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic global_irq_en,
	input wire logic irq,
	input wire logic sck_o,
	input wire logic sck_oe,
	input wire logic mosi_o,
	input wire logic mosi_oe,
	input wire logic miso_oe
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Read address phase accepted this cycle
	wire logic rd_take = clk_en && hsel && htrans[1] && hready && !hwrite;
	// Bus answers
	a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
	a_ready_high: assert property (hreadyout) else $error("wait state seen");
	a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
	a_status_reserved: assert property (rd_take && haddr == 32'h4 |=> hrdata[5:1] == 5'h0)
		else $error("reserved status bits set");
	a_unmapped_zero: assert property (rd_take && haddr > 32'h8 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	// Interrupt needs the global enable one cycle earlier
	a_irq_gated: assert property (clk_en && !global_irq_en |=> !irq)
		else $error("irq without global enable");
	// Master and slave drivers never overlap
	a_role_exclusive: assert property (!(miso_oe && sck_oe))
		else $error("both roles driving");
	a_master_pins: assert property (mosi_oe == sck_oe)
		else $error("master pins out of step");
	// Stalled clock enable must freeze outputs
	a_freeze_hold: assert property (!clk_en |=> $stable(sck_o) && $stable(mosi_o) && $stable(irq))
		else $error("output moved while frozen");
endmodule

bind spmc_top spmc_checker u_spmc_checker (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .hrdata, .global_irq_en, .irq, .sck_o, .sck_oe,
	.mosi_o, .mosi_oe, .miso_oe);

/* dv/spmc_peer.sv */
module spmc_peer (
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic clock_polarity_bit,
	input wire logic clock_phase_bit,
	input wire logic lsb,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv = 1'b0;
	int k = 0;
	// Outgoing bit i in the chosen order
	function automatic logic pick(input int i);
		return lsb ? tx_byte[i] : tx_byte[7 - i];
	endfunction
	// Released line flips, so a stale bit is never read back as good
	assign miso = ss_n ? ~drv : drv;
	// Select fall presents the first bit
	always @(negedge ss_n) begin
		k = 0;
		drv = pick(0);
	end
	// Sample and setup on opposite edges, modes 0..3
	always @(sck) begin
		if (!ss_n && ((sck != clock_polarity_bit) ^ clock_phase_bit))
			rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
		else if (!ss_n && clock_phase_bit) begin
			drv = pick(k % 8);
			k++;
		end else if (!ss_n) begin
			k++;
			drv = pick(k % 8);
		end
	end
endmodule

/* dv/spmc_top_bench.sv */
module spmc_top_bench
	import spmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ad_c = 32'(SPMC_ADDR_CTRL);
	localparam logic [31:0] ad_s = 32'(SPMC_ADDR_STAT);
	localparam logic [31:0] ad_d = 32'(SPMC_ADDR_DATA);
	logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h1ffbf96d;
	logic [1:0] htrans = 2'h0;
	logic gie = 1'b0, irq_ack = 1'b0, ss_is_input = 1'b0, ss_n_i = 1'b1, sck_i = 1'b0;
	logic mosi_i = 1'b0, peer_ss_n = 1'b1, clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0, lsb = 1'b0;
	logic hreadyout, hresp, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_i, miso_o, miso_oe;
	logic sck_q;
	logic [7:0] peer_tx = 8'h0, peer_rx, miso_cap = 8'h0;
	int failures = 0, num_checks = 0, cyc = 0, edges = 0, t0 = 0, half_m = 0;

	spmc_top u_spmc_top (
		.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .global_irq_en(gie), .irq_ack,
		.irq, .ss_is_input, .ss_n_i, .sck_i, .sck_o, .sck_oe, .mosi_i, .mosi_o, .mosi_oe,
		.miso_i, .miso_o, .miso_oe
	);
	spmc_peer u_spmc_peer (.sck(sck_o), .ss_n(peer_ss_n), .mosi(mosi_o), .clock_polarity_bit, .clock_phase_bit,
		.lsb, .tx_byte(peer_tx), .miso(miso_i), .rx_byte(peer_rx));

	initial forever #10 hclk = ~hclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Half serial period in hclk cycles
	function automatic int half_exp(input logic x2, input logic [1:0] r);
		int h;
		h = (r == 2'h3) ? 64 : 2 << (2 * r);
		return x2 ? h / 2 : h;
	endfunction
	task automatic print_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	// One single transfer plus an idle cycle, so reads never see stale data
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		@(posedge hclk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(a, 1'b1, d, v);
	endtask
	task automatic rd_chk(input string s, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] v;
		bus(a, 1'b0, 32'h0, v);
		chk(s, e, v);
	endtask
	// External master, mode 0, MSB first, slow enough for the input sync; takes miso at each rise
	task automatic send(input logic [7:0] b, input int n);
		for (int j = 7; j > 7 - n; j--) begin
			mosi_i <= b[j];
			repeat (8) @(posedge hclk);
			miso_cap = {miso_cap[6:0], miso_o};
			sck_i <= 1'b1;
			repeat (8) @(posedge hclk);
			sck_i <= 1'b0;
		end
		repeat (8) @(posedge hclk);
	endtask
	// Master byte with a colliding second write; rate, speed and mode from i
	task automatic xfer(input logic [2:0] i);
		logic [7:0] c;
		logic [1:0] m;
		logic ok;
		logic [31:0] v;
		seed = lfsr(seed);
		m = i[1:0] ^ {i[2], 1'b0};
		ok = i[1:0] != 2'h0 && !(i[2] && i[1:0] == 2'h1);
		{clock_polarity_bit, clock_phase_bit} <= m;
		lsb <= seed[16];
		gie <= seed[17];
		peer_tx <= seed[31:24];
		c = {1'b1, 1'b1, seed[16], 1'b1, m, i[1:0]};
		wr(ad_s, {31'h0, i[2]});
		wr(ad_c, {24'h0, c});
		// Select the peer only after a polarity change has reached the pin
		repeat (4) @(posedge hclk);
		chk("sck idle", {31'h0, m[1]}, {31'h0, sck_o});
		peer_ss_n <= 1'b0;
		edges = 0;
		wr(ad_d, {24'h0, seed[7:0]});
		wr(ad_d, {24'h0, seed[15:8]});
		repeat (1100) @(posedge hclk);
		chk("edges", 32'd16, edges);
		chk("half", half_exp(i[2], i[1:0]), half_m);
		chk("sck rest", {31'h0, m[1]}, {31'h0, sck_o});
		chk("irq", {31'h0, seed[17]}, {31'h0, irq});
		if (ok)
			chk("peer rx", {24'h0, seed[7:0]}, {24'h0, peer_rx});
		if (i[0]) begin
			irq_ack <= 1'b1;
			@(posedge hclk);
			irq_ack <= 1'b0;
			repeat (3) @(posedge hclk);
			chk("irq ack", 32'h0, {31'h0, irq});
		end
		rd_chk("flags", ad_s, {24'h0, !i[0], 7'h40 | i[2]});
		bus(ad_d, 1'b0, 32'h0, v);
		if (ok)
			chk("rx buf", {24'h0, seed[31:24]}, v);
		rd_chk("cleared", ad_s, {31'h0, i[2]});
		peer_ss_n <= 1'b1;
	endtask
	// Edge count, first half period, run limit
	always @(posedge hclk) begin
		cyc++;
		sck_q <= sck_o;
		if (sck_oe && sck_o !== sck_q) begin
			if (edges == 1)
				half_m = cyc - t0;
			t0 = cyc;
			edges++;
		end
		if (cyc == 20000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		logic [7:0] c;
		logic [31:0] v;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		clk_en <= 1'b0;
		repeat (3) @(posedge hclk);
		clk_en <= 1'b1;
		rd_chk("ctrl", ad_c, 32'h0);
		rd_chk("stat", ad_s, 32'h0);
		c = seed[7:0] & 8'haf;
		wr(ad_c, {24'h0, c});
		rd_chk("ctrl rw", ad_c, {24'h0, c});
		wr(ad_s, 32'hff);
		rd_chk("stat rw", ad_s, 32'h1);
		wr(32'hc, 32'hff);
		rd_chk("unmapped", 32'hc, 32'h0);
		wr(ad_s, 32'h0);
		// Master bit without enable: nothing moves
		c = 8'h10;
		wr(ad_c, {24'h0, c});
		wr(ad_d, 32'h3c);
		repeat (40) @(posedge hclk);
		chk("off edges", 32'h0, edges);
		rd_chk("off stat", ad_s, 32'h0);
		// Select pulled low while master
		c = 8'h50;
		wr(ad_c, {24'h0, c});
		ss_is_input <= 1'b1;
		ss_n_i <= 1'b0;
		repeat (6) @(posedge hclk);
		ss_n_i <= 1'b1;
		repeat (4) @(posedge hclk);
		rd_chk("fault ctrl", ad_c, 32'h40);
		rd_chk("fault stat", ad_s, 32'h80);
		bus(ad_d, 1'b0, 32'h0, v);
		ss_is_input <= 1'b0;
		// Slave with random rate bits, aborted partial byte first
		c = {6'h10, seed[1:0]};
		wr(ad_c, {24'h0, c});
		rd_chk("flags clr", ad_s, 32'h0);
		ss_n_i <= 1'b0;
		send(8'hff, 3);
		chk("miso oe", 32'h1, {31'h0, miso_oe});
		ss_n_i <= 1'b1;
		mosi_i <= ~mosi_i;
		repeat (8) @(posedge hclk);
		wr(ad_d, {24'h0, seed[23:16]});
		ss_n_i <= 1'b0;
		send(seed[15:8], 8);
		chk("slave tx", {24'h0, seed[23:16]}, {24'h0, miso_cap});
		ss_n_i <= 1'b1;
		rd_chk("slave done", ad_s, 32'h80);
		rd_chk("slave rx", ad_d, {24'h0, seed[15:8]});
		for (int i = 0; i < 8; i++)
			xfer(3'(i));
		print_verdict();
	end
endmodule
